/* File: pkg/dcr_pkg.sv */
package dcr_pkg;
  // Register addresses on the internal register port
  localparam logic [7:0] ADDR_RX_CTRL = 8'h1a;
  localparam logic [7:0] ADDR_CAP = 8'h1b;
  localparam logic [7:0] ADDR_VAR_HI = 8'h1c;
  localparam logic [7:0] ADDR_VAR_LO = 8'h1d;
  localparam logic [7:0] ADDR_DIV_CTRL = 8'h1e;
  localparam logic [7:0] ADDR_FRAC_HI = 8'h1f;
  localparam logic [7:0] ADDR_FRAC_MID = 8'h20;
  localparam logic [7:0] ADDR_FRAC_LO = 8'h21;
  localparam logic [7:0] ADDR_INT = 8'h22;
  localparam logic [7:0] ADDR_MOD_HI = 8'h23;
  localparam logic [7:0] ADDR_MOD_MID = 8'h24;
  localparam logic [7:0] ADDR_MOD_LO = 8'h25;

  // Writable bit masks; other positions read zero
  localparam logic [7:0] MASK_RX_CTRL = 8'h02;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_VAR_LO = 8'hfe;
  localparam logic [7:0] MASK_DIV_CTRL = 8'hf7;
  localparam logic [7:0] MASK_HI_NIBBLE = 8'hf0;
  localparam logic [7:0] MASK_INT = 8'hfc;

  // Reset values
  localparam logic [7:0] RST_RX_CTRL = 8'h00;
  localparam logic [7:0] RST_CAP = 8'h80;
  localparam logic [7:0] RST_VAR_HI = 8'h00;
  localparam logic [7:0] RST_VAR_LO = 8'h00;
  localparam logic [7:0] RST_DIV_CTRL = 8'h30;
  localparam logic [7:0] RST_FRAC_HI = 8'h40;
  localparam logic [7:0] RST_FRAC_MID = 8'h00;
  localparam logic [7:0] RST_FRAC_LO = 8'h00;
  localparam logic [7:0] RST_INT = 8'h40;
  localparam logic [7:0] RST_MOD_HI = 8'h80;
  localparam logic [7:0] RST_MOD_MID = 8'h00;
  localparam logic [7:0] RST_MOD_LO = 8'h00;

  // Field positions
  localparam int BIT_RX_PD_EN = 1;
  localparam int BIT_CAP_AUTO = 7;
  localparam int BIT_VAR_SW = 6;
  localparam int BIT_DOUBLER = 2;
  localparam int BIT_OSC_BYP = 1;
  localparam int BIT_SW_DIV = 7;
  localparam int BIT_SDM_BYP = 6;
  localparam int BIT_SDM_EN = 5;
  localparam int BIT_SEC_EN = 4;
  localparam int BIT_PRBS_DIS = 2;

  // Low-rate input divider codes and strap pattern
  localparam logic [1:0] LR_DIV2 = 2'h2;
  localparam logic [1:0] LR_DIV4 = 2'h3;
  localparam logic [3:0] STRAP_LOW_RATE = 4'hf;

  // Low-rate divider selection as a thermometer-coded ratio code (00, 01, 11)
  typedef enum logic [1:0] {
    DCR_LR_DIV1 = 2'h0,
    DCR_LR_DIV2 = 2'h1,
    DCR_LR_DIV4 = 2'h3
  } dcr_lrdiv_e;
endpackage

/* File: src/dcr_reg8.sv */
`timescale 1ns/1ps
// One 8-bit configuration register with per-bit write mask
module dcr_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);
  logic [7:0] next_q;

  // Masked-off bits hold their reset value forever
  assign next_q = wr_en ? ((wr_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK)) : q;

  // Synchronous reset register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= RESET_VALUE;
    end else begin
      q <= next_q;
    end
  end
endmodule

/* File: src/dcr_config.sv */
`timescale 1ns/1ps
module dcr_config #(
  parameter int CAP_W = 6,
  parameter int VAR_W = 13,
  parameter int FRAC_W = 20,
  parameter int INT_W = 6,
  parameter int MOD_W = 19
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [3:0] PRIMARY_RATE_STRAP,
  input wire logic [3:0] SECONDARY_RATE_STRAP,
  output logic CAP_AUTO,
  output logic [CAP_W-1:0] CAP_CODE,
  output logic VARACTOR_SW,
  output logic [VAR_W-1:0] VARACTOR_WORD,
  output logic DOUBLER_EN,
  output logic OSC_BYPASS,
  output logic PRIMARY_SW_DIVIDE,
  output logic PRIMARY_INTEGER_ONLY,
  output logic PRIMARY_SDM_RUN,
  output logic SECONDARY_RX_POWER_DOWN,
  output logic PRBS_DISABLE,
  output logic LOW_RATE_ACTIVE,
  output logic [1:0] LOW_RATE_DIV,
  output logic signed [FRAC_W-1:0] PRIMARY_FRACTION,
  output logic [INT_W-1:0] PRIMARY_INTEGER_DIVIDE,
  output logic [MOD_W-1:0] PRIMARY_MODULUS
);
  localparam int NREG = 12;

  // Register table: address, reset, mask per entry
  localparam logic [7:0] ADDR_TAB [NREG] = '{
    dcr_pkg::ADDR_RX_CTRL, dcr_pkg::ADDR_CAP, dcr_pkg::ADDR_VAR_HI,
    dcr_pkg::ADDR_VAR_LO, dcr_pkg::ADDR_DIV_CTRL, dcr_pkg::ADDR_FRAC_HI,
    dcr_pkg::ADDR_FRAC_MID, dcr_pkg::ADDR_FRAC_LO, dcr_pkg::ADDR_INT,
    dcr_pkg::ADDR_MOD_HI, dcr_pkg::ADDR_MOD_MID, dcr_pkg::ADDR_MOD_LO};
  localparam logic [7:0] RST_TAB [NREG] = '{
    dcr_pkg::RST_RX_CTRL, dcr_pkg::RST_CAP, dcr_pkg::RST_VAR_HI,
    dcr_pkg::RST_VAR_LO, dcr_pkg::RST_DIV_CTRL, dcr_pkg::RST_FRAC_HI,
    dcr_pkg::RST_FRAC_MID, dcr_pkg::RST_FRAC_LO, dcr_pkg::RST_INT,
    dcr_pkg::RST_MOD_HI, dcr_pkg::RST_MOD_MID, dcr_pkg::RST_MOD_LO};
  localparam logic [7:0] MASK_TAB [NREG] = '{
    dcr_pkg::MASK_RX_CTRL, dcr_pkg::MASK_FULL, dcr_pkg::MASK_FULL,
    dcr_pkg::MASK_VAR_LO, dcr_pkg::MASK_DIV_CTRL, dcr_pkg::MASK_FULL,
    dcr_pkg::MASK_FULL, dcr_pkg::MASK_HI_NIBBLE, dcr_pkg::MASK_INT,
    dcr_pkg::MASK_FULL, dcr_pkg::MASK_FULL, dcr_pkg::MASK_HI_NIBBLE};

  logic [7:0] regs [NREG];
  logic [NREG-1:0] hit;
  logic [7:0] rd_mux [NREG+1];
  logic [3:0] pstrap_s1, pstrap_s2, sstrap_s1, sstrap_s2;
  logic [7:0] r_rx, r_cap, r_vhi, r_vlo, r_ctl, r_fhi, r_fmid, r_flo, r_int, r_mhi, r_mmid;
  logic [7:0] r_mlo;
  logic strap_low_rate;
  logic [1:0] next_lr_div;
  logic [VAR_W-1:0] next_var;
  logic [FRAC_W-1:0] next_frac;
  logic [MOD_W-1:0] next_mod;

  // One register per table entry; masks keep unused bits at zero
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign hit[gi] = (REG_ADDR == ADDR_TAB[gi]);
      dcr_reg8 #(
        .RESET_VALUE(RST_TAB[gi]),
        .WRITE_MASK(MASK_TAB[gi])
      ) u_reg (
        .clock(CLOCK),
        .rst_n(RST_N),
        .wr_en(REG_WR && hit[gi]),
        .wr_data(REG_WDATA),
        .q(regs[gi])
      );
      assign rd_mux[gi+1] = rd_mux[gi] | (hit[gi] ? regs[gi] : 8'h00);
    end
  endgenerate
  assign rd_mux[0] = 8'h00;

  // Named views of the table
  assign r_rx = regs[0];
  assign r_cap = regs[1];
  assign r_vhi = regs[2];
  assign r_vlo = regs[3];
  assign r_ctl = regs[4];
  assign r_fhi = regs[5];
  assign r_fmid = regs[6];
  assign r_flo = regs[7];
  assign r_int = regs[8];
  assign r_mhi = regs[9];
  assign r_mmid = regs[10];
  assign r_mlo = regs[11];

  // Field assembly from split registers
  assign next_var = {r_vhi, r_vlo[7:3]};
  assign next_frac = {r_fhi, r_fmid, r_flo[7:4]};
  // Bit 7 of the modulus-high register is kept but never used; software writes zero
  assign next_mod = {r_mhi[6:0], r_mmid, r_mlo[7:4]};

  // Straps are pins, so they are synchronised before any use
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pstrap_s1 <= 4'h0;
      pstrap_s2 <= 4'h0;
      sstrap_s1 <= 4'h0;
      sstrap_s2 <= 4'h0;
    end else begin
      pstrap_s1 <= PRIMARY_RATE_STRAP;
      pstrap_s2 <= pstrap_s1;
      sstrap_s1 <= SECONDARY_RATE_STRAP;
      sstrap_s2 <= sstrap_s1;
    end
  end

  // Low-rate divider applies only when either strap set is all ones
  assign strap_low_rate = (pstrap_s2 == dcr_pkg::STRAP_LOW_RATE) ||
                          (sstrap_s2 == dcr_pkg::STRAP_LOW_RATE);
  // Codes 00 and 01 both mean divide by one
  assign next_lr_div = !strap_low_rate ? dcr_pkg::DCR_LR_DIV1 :
                       (r_ctl[1:0] == dcr_pkg::LR_DIV4) ? dcr_pkg::DCR_LR_DIV4 :
                       (r_ctl[1:0] == dcr_pkg::LR_DIV2) ? dcr_pkg::DCR_LR_DIV2 :
                       dcr_pkg::DCR_LR_DIV1;

  // Read data registered so the port comes from a flip-flop; unmapped reads zero
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rd_mux[NREG];
    end
  end

  // Oscillator controls, registered to give every output a flop
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      CAP_AUTO <= dcr_pkg::RST_CAP[dcr_pkg::BIT_CAP_AUTO];
      CAP_CODE <= '0;
      VARACTOR_SW <= 1'b0;
      VARACTOR_WORD <= '0;
      DOUBLER_EN <= 1'b0;
      OSC_BYPASS <= 1'b0;
    end else begin
      CAP_AUTO <= r_cap[dcr_pkg::BIT_CAP_AUTO];
      CAP_CODE <= r_cap[CAP_W-1:0];
      VARACTOR_SW <= r_cap[dcr_pkg::BIT_VAR_SW];
      VARACTOR_WORD <= next_var;
      DOUBLER_EN <= r_vlo[dcr_pkg::BIT_DOUBLER];
      OSC_BYPASS <= r_vlo[dcr_pkg::BIT_OSC_BYP];
    end
  end

  // Primary divider controls
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      PRIMARY_SW_DIVIDE <= 1'b0;
      PRIMARY_INTEGER_ONLY <= 1'b0;
      PRIMARY_SDM_RUN <= dcr_pkg::RST_DIV_CTRL[dcr_pkg::BIT_SDM_EN];
      SECONDARY_RX_POWER_DOWN <= 1'b0;
      PRBS_DISABLE <= 1'b0;
      LOW_RATE_ACTIVE <= 1'b0;
      LOW_RATE_DIV <= dcr_pkg::DCR_LR_DIV1;
    end else begin
      PRIMARY_SW_DIVIDE <= r_ctl[dcr_pkg::BIT_SW_DIV];
      PRIMARY_INTEGER_ONLY <= r_ctl[dcr_pkg::BIT_SDM_BYP];
      PRIMARY_SDM_RUN <= r_ctl[dcr_pkg::BIT_SDM_EN];
      // Power-down needs the global enable in the receiver control register
      SECONDARY_RX_POWER_DOWN <= !r_ctl[dcr_pkg::BIT_SEC_EN] &&
                                 r_rx[dcr_pkg::BIT_RX_PD_EN];
      PRBS_DISABLE <= r_ctl[dcr_pkg::BIT_PRBS_DIS];
      LOW_RATE_ACTIVE <= strap_low_rate;
      LOW_RATE_DIV <= next_lr_div;
    end
  end

  // Divider values; the fraction is carried as signed twos complement
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      PRIMARY_FRACTION <= $signed({dcr_pkg::RST_FRAC_HI, dcr_pkg::RST_FRAC_MID,
                                   dcr_pkg::RST_FRAC_LO[7:4]});
      PRIMARY_INTEGER_DIVIDE <= dcr_pkg::RST_INT[7:2];
      PRIMARY_MODULUS <= '0;
    end else begin
      PRIMARY_FRACTION <= $signed(next_frac);
      PRIMARY_INTEGER_DIVIDE <= r_int[7:2];
      PRIMARY_MODULUS <= next_mod;
    end
  end
endmodule

/* File: testbench/dcr_config_checker.sv */
`timescale 1ns/1ps
// Watches the register port and the configuration levels of the bank
module dcr_config_checker #(
  parameter int CAP_W = 6,
  parameter int VAR_W = 13,
  parameter int FRAC_W = 20,
  parameter int INT_W = 6,
  parameter int MOD_W = 19
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic [3:0] PRIMARY_RATE_STRAP,
  input wire logic [3:0] SECONDARY_RATE_STRAP,
  input wire logic CAP_AUTO,
  input wire logic [CAP_W-1:0] CAP_CODE,
  input wire logic VARACTOR_SW,
  input wire logic [VAR_W-1:0] VARACTOR_WORD,
  input wire logic DOUBLER_EN,
  input wire logic OSC_BYPASS,
  input wire logic PRIMARY_SW_DIVIDE,
  input wire logic PRIMARY_INTEGER_ONLY,
  input wire logic PRIMARY_SDM_RUN,
  input wire logic SECONDARY_RX_POWER_DOWN,
  input wire logic PRBS_DISABLE,
  input wire logic LOW_RATE_ACTIVE,
  input wire logic [1:0] LOW_RATE_DIV,
  input wire logic signed [FRAC_W-1:0] PRIMARY_FRACTION,
  input wire logic [INT_W-1:0] PRIMARY_INTEGER_DIVIDE,
  input wire logic [MOD_W-1:0] PRIMARY_MODULUS
);
  // A write lands on the levels two edges after it is taken
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  cap_field_a: assert property (REG_WR && REG_ADDR == 8'h1b |-> ##2
    {CAP_AUTO, VARACTOR_SW, CAP_CODE} == $past(REG_WDATA, 2)) else $error("cap byte lost");
  var_high_a: assert property (REG_WR && REG_ADDR == 8'h1c |-> ##2
    VARACTOR_WORD[12:5] == $past(REG_WDATA, 2)) else $error("varactor high lost");
  var_low_a: assert property (REG_WR && REG_ADDR == 8'h1d |-> ##2
    {VARACTOR_WORD[4:0], DOUBLER_EN, OSC_BYPASS} == $past(REG_WDATA[7:1], 2))
    else $error("varactor low or path bits lost");
  div_ctrl_a: assert property (REG_WR && REG_ADDR == 8'h1e |-> ##2
    {PRIMARY_SW_DIVIDE, PRIMARY_INTEGER_ONLY, PRIMARY_SDM_RUN, PRBS_DISABLE}
    == {$past(REG_WDATA[7:5], 2), $past(REG_WDATA[2], 2)}) else $error("divider control lost");
  rx_enable_a: assert property (REG_WR && REG_ADDR == 8'h1e && REG_WDATA[4] |-> ##2
    !SECONDARY_RX_POWER_DOWN) else $error("receiver down while enabled");
  rx_gate_a: assert property (REG_WR && REG_ADDR == 8'h1a && !REG_WDATA[1] |-> ##2
    !SECONDARY_RX_POWER_DOWN) else $error("receiver down while gate off");
  frac_high_a: assert property (REG_WR && REG_ADDR == 8'h1f |-> ##2
    PRIMARY_FRACTION[19:12] == $past(REG_WDATA, 2)) else $error("fraction high lost");
  int_div_a: assert property (REG_WR && REG_ADDR == 8'h22 |-> ##2
    PRIMARY_INTEGER_DIVIDE == $past(REG_WDATA[7:2], 2)) else $error("integer divide lost");
  mod_high_a: assert property (REG_WR && REG_ADDR == 8'h23 |-> ##2
    PRIMARY_MODULUS[18:12] == $past(REG_WDATA[6:0], 2)) else $error("modulus high lost");
  low_rate_off_a: assert property (!LOW_RATE_ACTIVE |-> LOW_RATE_DIV == 2'h0)
    else $error("low-rate divider active without straps");
  unmapped_rd_a: assert property (REG_RD && (REG_ADDR < 8'h1a || REG_ADDR > 8'h25)
    |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
  // Main scenarios reached
  cover property (REG_WR && REG_ADDR == 8'h1e && REG_WDATA[7] ##2 PRIMARY_SW_DIVIDE);
  cover property (LOW_RATE_ACTIVE && LOW_RATE_DIV == 2'h3);
  cover property (SECONDARY_RX_POWER_DOWN);
endmodule
bind dcr_config dcr_config_checker #(.CAP_W(CAP_W), .VAR_W(VAR_W), .FRAC_W(FRAC_W),
  .INT_W(INT_W), .MOD_W(MOD_W)) i_dcr_config_checker (.*);

/* File: testbench/tb_dcr_config.sv */
`timescale 1ns/1ps
// Self-checking bench for the oscillator and primary divider bank
module tb_dcr_config;
  logic CLOCK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, a, d;
  logic [3:0] PRIMARY_RATE_STRAP = 4'h0, SECONDARY_RATE_STRAP = 4'h0;
  logic CAP_AUTO, VARACTOR_SW, DOUBLER_EN, OSC_BYPASS, PRIMARY_SW_DIVIDE, PRIMARY_INTEGER_ONLY;
  logic PRIMARY_SDM_RUN, SECONDARY_RX_POWER_DOWN, PRBS_DISABLE, LOW_RATE_ACTIVE;
  logic [1:0] LOW_RATE_DIV;
  logic [5:0] CAP_CODE, PRIMARY_INTEGER_DIVIDE;
  logic [12:0] VARACTOR_WORD;
  logic signed [19:0] PRIMARY_FRACTION;
  logic [18:0] PRIMARY_MODULUS;
  logic [7:0] mirror [8'h18:8'h27];
  integer seed = 32'h46ce;
  int err_total = 0, checks_done = 0, cyc = 0;

  dcr_config i_dcr_config (.*);

  always #20 CLOCK = ~CLOCK;

  // Writable bits per address; unmapped neighbours keep nothing
  function automatic logic [7:0] wmask(input logic [7:0] ad);
    case (ad)
      8'h1a: return 8'h02;
      8'h1d: return 8'hfe;
      8'h1e: return 8'hf7;
      8'h21, 8'h25: return 8'hf0;
      8'h22: return 8'hfc;
      default: return (ad > 8'h1a && ad < 8'h26) ? 8'hff : 8'h00;
    endcase
  endfunction
  // Contents right after reset
  function automatic logic [7:0] rst_val(input logic [7:0] ad);
    case (ad)
      8'h1b, 8'h23: return 8'h80;
      8'h1e: return 8'h30;
      8'h1f, 8'h22: return 8'h40;
      default: return 8'h00;
    endcase
  endfunction
  // Expected {active, ratio code}; straps must have settled
  function automatic logic [2:0] lr_exp(input logic [1:0] code);
    if (PRIMARY_RATE_STRAP != 4'hf && SECONDARY_RATE_STRAP != 4'hf) return 3'h0;
    return {1'b1, code == 2'h3 ? 2'h3 : {1'b0, code[1]}};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge CLOCK);
    REG_WR <= 1'b1;
    REG_ADDR <= ad;
    REG_WDATA <= dt;
    mirror[ad] = dt & wmask(ad);
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] ad);
    @(posedge CLOCK);
    REG_RD <= 1'b1;
    REG_ADDR <= ad;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    @(negedge CLOCK);
    chk(REG_RDATA, mirror[ad]);
  endtask

  // Four edges cover both the write path and the strap synchroniser
  task automatic chk_outs();
    repeat (4) @(posedge CLOCK);
    #1;
    chk({CAP_AUTO, VARACTOR_SW, CAP_CODE}, mirror[8'h1b]);
    chk(VARACTOR_WORD, {mirror[8'h1c], mirror[8'h1d][7:3]});
    chk({DOUBLER_EN, OSC_BYPASS}, mirror[8'h1d][2:1]);
    chk({PRIMARY_SW_DIVIDE, PRIMARY_INTEGER_ONLY}, mirror[8'h1e][7:6]);
    chk({PRIMARY_SDM_RUN, PRBS_DISABLE}, {mirror[8'h1e][5], mirror[8'h1e][2]});
    chk(SECONDARY_RX_POWER_DOWN, !mirror[8'h1e][4] & mirror[8'h1a][1]);
    // Both sides sign-extend, so a set top bit must come out negative
    chk(PRIMARY_FRACTION,
      $signed({mirror[8'h1f], mirror[8'h20], mirror[8'h21][7:4]}));
    chk(PRIMARY_INTEGER_DIVIDE, mirror[8'h22][7:2]);
    chk(PRIMARY_MODULUS, {mirror[8'h23][6:0], mirror[8'h24], mirror[8'h25][7:4]});
    chk({LOW_RATE_ACTIVE, LOW_RATE_DIV}, lr_exp(mirror[8'h1e][1:0]));
  endtask

  task automatic all_regs(input string name);
    for (int i = 8'h18; i <= 8'h27; i++) rd_chk(8'(i));
    chk_outs();
    $display("test %s done", name);
  endtask

  task automatic do_reset();
    @(posedge CLOCK);
    RST_N <= 1'b0;
    repeat (16) @(posedge CLOCK);
    RST_N <= 1'b1;
    for (int i = 8'h18; i <= 8'h27; i++) mirror[i] = rst_val(8'(i));
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Cuts a hang short; the full run needs well under half of this
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    do_reset();
    all_regs("reset");
    // Back-to-back writes with reads and strap noise mixed in
    repeat (300) begin
      @(posedge CLOCK);
      a = 8'h18 + 8'({$random(seed)} % 16);
      d = 8'($random(seed));
      if (a == 8'h23) d[7] = 1'b0;
      REG_WR <= 1'b1;
      REG_RD <= 1'($random(seed));
      REG_ADDR <= a;
      REG_WDATA <= d;
      PRIMARY_RATE_STRAP <= 4'($random(seed));
      mirror[a] = d & wmask(a);
    end
    wr(8'h1a, 8'hff);
    all_regs("random");
    // Software keeps the spare top bit of the modulus-high byte at zero
    for (int i = 8'h1a; i <= 8'h25; i++) wr(8'(i), (i == 8'h23) ? 8'h7f : 8'hff);
    all_regs("all_ones");
    // Every ratio code with primary, secondary and no strap at all ones
    for (int k = 0; k < 12; k++) begin
      @(posedge CLOCK);
      PRIMARY_RATE_STRAP <= (k / 4 == 0) ? 4'hf : 4'($random(seed)) & 4'he;
      SECONDARY_RATE_STRAP <= (k / 4 == 1) ? 4'hf : 4'($random(seed)) & 4'h7;
      wr(8'h1e, (mirror[8'h1e] & 8'hfc) | 8'(k % 4));
      chk_outs();
    end
    $display("test low_rate done");
    do_reset();
    all_regs("second_reset");
    end_of_test();
  end
endmodule
